// ===== flash_cmd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.svh"

// Behaviour
// - sleep only via sleep opcode; writes ignored
// - asleep, only wake opcode decoded; it wakes
// - wake-only frame: first resume delay, then ready
// - ID read: three dummies, ID repeats MSB first
// - deselect from sleep waits second resume delay
// - wake opcode works awake; dropped while busy
// - manufacturer then device code after zero address
// - address one swaps code order
// - identification: maker, memory type, capacity bytes
// - identification not decoded while busy
// - deselect ends identification output, back to standby
// - otp mode maps otp sector onto sector 511
// - otp mode: protect bit shows lock; lock blocks
// - otp mode status write sets lock bit
// - otp sector needs lock zero, protect 0000
// - write-disable opcode leaves otp mode
// - otp mode accepts sector erase and page program only
// - table read: opcode, address, dummy, then data
// - table address increments and wraps to zero
// - table read rejected while busy
// - header bytes 00h-07h: signature and revisions
// - header bytes 08h-0Fh: parameter header, pointer
module flash_cmd_top #(
  // identity values are arbitrary
  parameter logic [7:0] MFR_CODE = 8'hA5,
  parameter logic [7:0] DEV_CODE = 8'h14,
  parameter logic [7:0] MEM_TYPE = 8'h70,
  parameter logic [7:0] MEM_CAPACITY = 8'h15
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // serial link
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  // array engine
  input wire logic ARRAY_BUSY,
  output logic ARRAY_REQ,
  output logic [7:0] ARRAY_REQ_OP,
  output logic [23:0] ARRAY_REQ_ADDR,
  output logic ARRAY_REQ_OTP,
  output logic OTP_MAP,
  output logic DEEP_SLEEP,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA
);

  logic [2:0] pins_s;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic sck_prev_q;
  logic cs_prev_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;

  flash_cmd_pkg::phase_e phase_q;
  logic [6:0] rx_q;
  logic [2:0] bit_q;
  logic [2:0] nbytes_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [2:0] need_len;

  logic [2:0] obit_q;
  logic [1:0] oidx_q;
  logic [7:0] prm_addr_q;
  logic [7:0] prm_byte;
  logic [7:0] cur_byte;
  logic [7:0] status_byte;

  logic sleep_q;
  logic [`RES_CNT_W-1:0] resume_q;
  logic otp_mode_q;
  logic otp_lock_q;
  logic [3:0] bp_q;
  logic prot_q;
  logic [7:0] last_op_q;

  logic act;
  logic whole;
  logic otp_hit;
  logic is_write_op;
  logic len_ok;
  logic write_ok;

  // link pins come from another clock domain
  pin_sync #(
    .W(3),
    .RST_VAL(3'h1)
  ) u_pin_sync (
    .clk(REF_CLK),
    .rst_n(NRST),
    .d({SI, SCK, CS_N}),
    .q(pins_s)
  );

  assign cs_n_s = pins_s[0];
  assign sck_s = pins_s[1];
  assign si_s = pins_s[2];

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_n_s;
    end
  end

  assign sck_rise = ~sck_prev_q & sck_s & ~cs_n_s;
  assign sck_fall = sck_prev_q & ~sck_s & ~cs_n_s;
  assign cs_rise = ~cs_prev_q & cs_n_s;
  assign rx_byte = {rx_q, si_s};
  assign byte_done = sck_rise & (bit_q == 3'h7);

  // bytes needed before the output phase starts
  always_comb begin
    case (op_q)
      `OP_WAKE_ID: need_len = `LEN_WAKE_ID;
      `OP_MFR_DEV_ID: need_len = `LEN_MFR_DEV;
      `OP_PARAM_READ: need_len = `LEN_PARAM_READ;
      default: need_len = `LEN_NONE;
    endcase
  end

  // input shifter: sampled on rising clock edges
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rx_q <= 7'h00;
      bit_q <= 3'h0;
      nbytes_q <= 3'h0;
    end else if (cs_n_s) begin
      bit_q <= 3'h0;
      nbytes_q <= 3'h0;
    end else if (sck_rise) begin
      rx_q <= rx_byte[6:0];
      bit_q <= bit_q + 3'h1;
      if (byte_done && nbytes_q != `LEN_MAX) begin
        nbytes_q <= nbytes_q + 3'h1;
      end
    end
  end

  // opcode and address capture
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      op_q <= 8'h00;
      addr_q <= 24'h000000;
    end else if (byte_done) begin
      if (nbytes_q == 3'h0) begin
        op_q <= rx_byte;
      end else if (nbytes_q < `LEN_ADDR_CMD) begin
        addr_q <= {addr_q[15:0], rx_byte};
      end
    end
  end

  // frame phase
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      phase_q <= flash_cmd_pkg::PH_CMD;
    end else if (cs_n_s) begin
      phase_q <= flash_cmd_pkg::PH_CMD;
    end else if (byte_done) begin
      case (phase_q)
        flash_cmd_pkg::PH_CMD: begin
          // asleep: all but wake dropped; resuming: wake dropped too
          if (sleep_q && (rx_byte != `OP_WAKE_ID || resume_q != '0)) begin
            phase_q <= flash_cmd_pkg::PH_DROP;
          end else if (ARRAY_BUSY && (rx_byte == `OP_WAKE_ID ||
                       rx_byte == `OP_IDENT ||
                       rx_byte == `OP_PARAM_READ)) begin
            phase_q <= flash_cmd_pkg::PH_DROP;
          end else if (rx_byte == `OP_IDENT ||
                       rx_byte == `OP_STATUS_READ) begin
            phase_q <= flash_cmd_pkg::PH_OUT;
          end else begin
            phase_q <= flash_cmd_pkg::PH_ARG;
          end
        end
        flash_cmd_pkg::PH_ARG: begin
          if (need_len != `LEN_NONE &&
              nbytes_q + 3'h1 == need_len) begin
            phase_q <= flash_cmd_pkg::PH_OUT;
          end
        end
        default: phase_q <= phase_q;
      endcase
    end
  end

  param_header_rom u_param_rom (
    .addr(prm_addr_q),
    .data(prm_byte)
  );

  // otp mode shows the lock in the protect position
  always_comb begin
    status_byte = 8'h00;
    status_byte[`ST_PROT_BIT] = otp_mode_q ? otp_lock_q : prot_q;
    status_byte[`ST_BP_MSB:`ST_BP_LSB] = bp_q;
    status_byte[`ST_BUSY_BIT] = ARRAY_BUSY;
  end

  always_comb begin
    case (op_q)
      // same ID byte repeats until deselect
      `OP_WAKE_ID: cur_byte = DEV_CODE;
      // address bit 0 swaps the order
      `OP_MFR_DEV_ID: cur_byte = (oidx_q[0] ^ addr_q[0]) ? DEV_CODE :
                                 MFR_CODE;
      `OP_IDENT: begin
        if (oidx_q == 2'h0) begin
          cur_byte = MFR_CODE;
        end else if (oidx_q == 2'h1) begin
          cur_byte = MEM_TYPE;
        end else begin
          cur_byte = MEM_CAPACITY;
        end
      end
      `OP_PARAM_READ: cur_byte = prm_byte;
      default: cur_byte = status_byte;
    endcase
  end

  // output shifter: driven on falling clock edges
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      obit_q <= 3'h0;
      oidx_q <= 2'h0;
      prm_addr_q <= 8'h00;
      SO <= 1'b0;
    end else if (cs_n_s) begin
      obit_q <= 3'h0;
      oidx_q <= 2'h0;
    end else if (byte_done && phase_q != flash_cmd_pkg::PH_OUT) begin
      // address is complete before the dummy byte ends
      prm_addr_q <= addr_q[7:0];
    end else if (sck_fall && phase_q == flash_cmd_pkg::PH_OUT) begin
      SO <= cur_byte[3'h7 - obit_q];
      obit_q <= obit_q + 3'h1;
      if (obit_q == 3'h7) begin
        // 8-bit counter rolls over to zero
        prm_addr_q <= prm_addr_q + 8'h01;
        // only the three-byte identity wraps; two-code reads alternate
        oidx_q <= (oidx_q == 2'h2 && op_q == `OP_IDENT) ? 2'h0 :
                  oidx_q + 2'h1;
      end
    end
  end

  // deselect releases the output at once
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      SO_OE <= 1'b0;
    end else if (cs_n_s) begin
      SO_OE <= 1'b0;
    end else if (sck_fall && phase_q == flash_cmd_pkg::PH_OUT) begin
      SO_OE <= 1'b1;
    end
  end

  // commands below act only on a clean deselect
  assign act = cs_rise && phase_q != flash_cmd_pkg::PH_DROP && !sleep_q;
  assign whole = (bit_q == 3'h0);

  // deep sleep and resume timing
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      sleep_q <= 1'b0;
      resume_q <= '0;
    end else if (resume_q != '0) begin
      resume_q <= resume_q - `RES_CNT_W'(1);
      if (resume_q == `RES_CNT_W'(1)) begin
        sleep_q <= 1'b0;
      end
    // only the sleep opcode, never during a busy cycle
    end else if (act && whole && op_q == `OP_DEEP_SLEEP &&
                 nbytes_q == `LEN_OPCODE_ONLY && !ARRAY_BUSY) begin
      sleep_q <= 1'b1;
    end else if (cs_rise && sleep_q && op_q == `OP_WAKE_ID &&
                 nbytes_q != 3'h0 &&
                 phase_q != flash_cmd_pkg::PH_DROP) begin
      // wake-only frame uses the first delay
      // a frame that read the ID uses the second
      resume_q <= (nbytes_q > `LEN_OPCODE_ONLY) ?
                  `RES_CNT_W'(`RES2_CYC) : `RES_CNT_W'(`RES1_CYC);
    end
  end

  // otp mode and lock bit
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      otp_mode_q <= 1'b0;
    end else if (act && whole && op_q == `OP_OTP_ENTER &&
                 nbytes_q == `LEN_OPCODE_ONLY && !ARRAY_BUSY) begin
      otp_mode_q <= 1'b1;
    end else if (act && whole && op_q == `OP_WRITE_DISABLE &&
                 nbytes_q == `LEN_OPCODE_ONLY) begin
      otp_mode_q <= 1'b0;
    end
  end

  // lock is one-time: nothing but reset clears it
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      otp_lock_q <= 1'b0;
    // data byte ignored, lock goes to one
    end else if (act && whole && otp_mode_q && !ARRAY_BUSY &&
                 op_q == `OP_STATUS_WRITE &&
                 nbytes_q == `LEN_STATUS_WRITE) begin
      otp_lock_q <= 1'b1;
    end
  end

  // address inside the remapped otp sector
  assign otp_hit = otp_mode_q &&
                   addr_q[23:`OTP_ADDR_LSB] == `OTP_SECT_TAG;

  always_comb begin
    is_write_op = 1'b1;
    len_ok = 1'b0;
    case (op_q)
      `OP_PAGE_PROG: len_ok = (nbytes_q >= `LEN_PROG_MIN);
      `OP_SECTOR_ERASE: len_ok = (nbytes_q == `LEN_ADDR_CMD);
      `OP_BLOCK_ERASE: len_ok = (nbytes_q == `LEN_ADDR_CMD);
      `OP_CHIP_ERASE_A: len_ok = (nbytes_q == `LEN_OPCODE_ONLY);
      `OP_CHIP_ERASE_B: len_ok = (nbytes_q == `LEN_OPCODE_ONLY);
      default: is_write_op = 1'b0;
    endcase
  end

  always_comb begin
    write_ok = is_write_op && len_ok;
    if (otp_mode_q) begin
      // lock set blocks every program and erase
      if (otp_lock_q) begin
        write_ok = 1'b0;
      end
      // sector erase is the only erase in otp mode
      if (op_q != `OP_PAGE_PROG && op_q != `OP_SECTOR_ERASE) begin
        write_ok = 1'b0;
      end
      // otp sector also needs protect field clear
      if (otp_hit && bp_q != 4'h0) begin
        write_ok = 1'b0;
      end
    end
  end

  // sleep drops writes; busy cycles stay untouched
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ARRAY_REQ <= 1'b0;
      ARRAY_REQ_OP <= 8'h00;
      ARRAY_REQ_ADDR <= 24'h000000;
      ARRAY_REQ_OTP <= 1'b0;
    end else begin
      ARRAY_REQ <= act && whole && write_ok && !ARRAY_BUSY;
      if (act && whole && write_ok && !ARRAY_BUSY) begin
        ARRAY_REQ_OP <= op_q;
        ARRAY_REQ_ADDR <= addr_q;
        ARRAY_REQ_OTP <= otp_hit;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      OTP_MAP <= 1'b0;
      DEEP_SLEEP <= 1'b0;
    end else begin
      OTP_MAP <= otp_mode_q;
      DEEP_SLEEP <= sleep_q;
    end
  end

  // software view: protect field in, block state out
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      bp_q <= 4'h0;
      prot_q <= 1'b0;
    end else if (REG_WR && REG_ADDR == `REG_CFG) begin
      bp_q <= REG_WDATA[3:0];
      prot_q <= REG_WDATA[`CFG_PROT_BIT];
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      last_op_q <= 8'h00;
    end else if (byte_done && phase_q == flash_cmd_pkg::PH_CMD) begin
      last_op_q <= rx_byte;
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 8'h00;
    end else if (!REG_RD) begin
      REG_RDATA <= 8'h00;
    end else if (REG_ADDR == `REG_CFG) begin
      REG_RDATA <= {prot_q, 3'h0, bp_q};
    end else if (REG_ADDR == `REG_STATE) begin
      REG_RDATA <= {3'h0, otp_lock_q, otp_mode_q, resume_q != '0,
                    sleep_q, ARRAY_BUSY};
    end else if (REG_ADDR == `REG_LAST_OP) begin
      REG_RDATA <= last_op_q;
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

endmodule : flash_cmd_top

`default_nettype wire

// ===== flash_cmd_consts.svh
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// opcodes
`define OP_WAKE_ID 8'hAB
`define OP_MFR_DEV_ID 8'h90
`define OP_IDENT 8'h9F
`define OP_DEEP_SLEEP 8'hB9
`define OP_OTP_ENTER 8'h3A
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_PAGE_PROG 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'hC7
`define OP_CHIP_ERASE_B 8'h60
`define OP_PARAM_READ 8'h5A

// frame lengths in whole bytes, opcode included
`define LEN_OPCODE_ONLY 3'h1
`define LEN_STATUS_WRITE 3'h2
`define LEN_ADDR_CMD 3'h4
`define LEN_PROG_MIN 3'h5
`define LEN_WAKE_ID 3'h4
`define LEN_MFR_DEV 3'h4
`define LEN_IDENT 3'h1
`define LEN_STATUS_READ 3'h1
`define LEN_PARAM_READ 3'h5
`define LEN_NONE 3'h0
`define LEN_MAX 3'h7

// otp sector 511: 1FF000h..1FF1FFh, tag is address bits 23:9
`define OTP_SECT_TAG 15'h0FF8
`define OTP_ADDR_LSB 9

// parameter header bytes 00h..0Fh
`define PRM_00 8'h53
`define PRM_01 8'h46
`define PRM_02 8'h44
`define PRM_03 8'h50
`define PRM_04 8'h00
`define PRM_05 8'h01
`define PRM_06 8'h00
`define PRM_07 8'hFF
`define PRM_08 8'h00
`define PRM_09 8'h00
`define PRM_0A 8'h01
`define PRM_0B 8'h09
`define PRM_0C 8'h30
`define PRM_0D 8'h00
`define PRM_0E 8'h00
`define PRM_0F 8'hFF
`define PRM_BLANK 8'hFF
`define PRM_HDR_TOP 8'h0F

// timing
`define CLK_PERIOD_NS 8
`define RES1_NS 3000
`define RES2_NS 1800
`define RES1_CYC (`RES1_NS / `CLK_PERIOD_NS)
`define RES2_CYC (`RES2_NS / `CLK_PERIOD_NS)
`define RES_CNT_W 12

// status byte bit positions
`define ST_PROT_BIT 7
`define ST_BP_MSB 5
`define ST_BP_LSB 2
`define ST_BUSY_BIT 0

// register port
`define REG_CFG 8'h00
`define REG_STATE 8'h01
`define REG_LAST_OP 8'h02
`define CFG_PROT_BIT 7

`endif

// ===== flash_cmd_pkg.sv
`default_nettype none

package flash_cmd_pkg;

  typedef enum logic [1:0] {
    PH_CMD,
    PH_ARG,
    PH_OUT,
    PH_DROP
  } phase_e;

endpackage : flash_cmd_pkg

`default_nettype wire

// ===== pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // meta_q feeds q only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule : pin_sync

`default_nettype wire

// ===== param_header_rom.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.svh"

module param_header_rom (
  // lookup
  input wire logic [7:0] addr,
  output logic [7:0] data
);

  always_comb begin
    data = `PRM_BLANK;
    if (addr <= `PRM_HDR_TOP) begin
      case (addr[3:0])
        4'h0: data = `PRM_00;
        4'h1: data = `PRM_01;
        4'h2: data = `PRM_02;
        4'h3: data = `PRM_03;
        4'h4: data = `PRM_04;
        4'h5: data = `PRM_05;
        4'h6: data = `PRM_06;
        4'h7: data = `PRM_07;
        4'h8: data = `PRM_08;
        4'h9: data = `PRM_09;
        4'hA: data = `PRM_0A;
        4'hB: data = `PRM_0B;
        4'hC: data = `PRM_0C;
        4'hD: data = `PRM_0D;
        4'hE: data = `PRM_0E;
        default: data = `PRM_0F;
      endcase
    end
  end

endmodule : param_header_rom

`default_nettype wire

// ===== flash_cmd_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.svh"

module flash_cmd_props (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // serial link
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SO,
  input wire logic SO_OE,
  // array engine
  input wire logic ARRAY_REQ,
  input wire logic [7:0] ARRAY_REQ_OP,
  input wire logic [23:0] ARRAY_REQ_ADDR,
  input wire logic ARRAY_REQ_OTP,
  input wire logic OTP_MAP,
  input wire logic DEEP_SLEEP
);
  logic [9:0] hi_cnt_q;
  logic otp_hit;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  // deselected run length, saturates so long idles never wrap
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      hi_cnt_q <= 10'h000;
    end else if (!CS_N) begin
      hi_cnt_q <= 10'h000;
    end else if (hi_cnt_q != 10'h3FF) begin
      hi_cnt_q <= hi_cnt_q + 10'h001;
    end
  end

  assign otp_hit = ARRAY_REQ_ADDR[23:`OTP_ADDR_LSB] == `OTP_SECT_TAG;

  sequence s_quiet;
    CS_N [*8];
  endsequence
  sequence s_req_otp;
    ARRAY_REQ && OTP_MAP;
  endsequence

  chk_oe_after_desel: assert property (s_quiet |-> !SO_OE)
    else $error("output enable still high after deselect");
  chk_so_on_fall: assert property (
    $changed(SO) && SO_OE |-> !$past(SCK, 2))
    else $error("serial output moved while clock high");
  chk_sleep_on_desel: assert property (
    $rose(DEEP_SLEEP) |-> CS_N && $past(CS_N, 2))
    else $error("sleep entered while selected");
  chk_no_req_asleep: assert property (DEEP_SLEEP |-> !ARRAY_REQ)
    else $error("array request while asleep");
  chk_otp_on_desel: assert property (
    $rose(OTP_MAP) |-> CS_N && $past(CS_N, 2))
    else $error("otp mode entered while selected");
  chk_otp_erase_op: assert property (
    s_req_otp |-> ARRAY_REQ_OP inside {`OP_SECTOR_ERASE, `OP_PAGE_PROG})
    else $error("erase other than sector erase in otp mode");
  chk_otp_tag: assert property (
    ARRAY_REQ && ARRAY_REQ_OTP |-> OTP_MAP && otp_hit)
    else $error("otp target outside sector 511");
  chk_otp_remap: assert property (
    s_req_otp ##0 otp_hit |-> ARRAY_REQ_OTP)
    else $error("sector 511 not remapped in otp mode");
  chk_resume_span: assert property (
    $fell(DEEP_SLEEP) |-> hi_cnt_q inside {[`RES2_CYC:`RES1_CYC + 8]})
    else $error("resume delay length wrong");
endmodule : flash_cmd_props

bind flash_cmd_top flash_cmd_props i_props (.REF_CLK(REF_CLK), .NRST(NRST),
  .CS_N(CS_N), .SCK(SCK), .SO(SO), .SO_OE(SO_OE), .ARRAY_REQ(ARRAY_REQ),
  .ARRAY_REQ_OP(ARRAY_REQ_OP), .ARRAY_REQ_ADDR(ARRAY_REQ_ADDR),
  .ARRAY_REQ_OTP(ARRAY_REQ_OTP), .OTP_MAP(OTP_MAP), .DEEP_SLEEP(DEEP_SLEEP));

`default_nettype wire

// ===== spi_host.sv
`timescale 1ns/1ps
`default_nettype none

module spi_host (
  // serial link
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  logic [63:0] rx;
  logic oe_seen;
  event done;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  task automatic shift(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      // drive on fall, device latches on rise
      si = b[i];
      #62.5 sck = 1'b1;
      // an undriven line reads as the inverse of its last value
      rx = {rx[62:0], so_oe ? so : ~so};
      oe_seen = oe_seen | so_oe;
      #62.5 sck = 1'b0;
    end
  endtask : shift

  task automatic frame(input logic [7:0] tx[$], input int nout, input int gap);
    rx = '0;
    oe_seen = 1'b0;
    cs_n = 1'b0;
    foreach (tx[i]) shift(tx[i]);
    for (int i = 0; i < nout; i++) shift(8'h55);
    // whole bytes only, clock parked low before deselect
    #62.5 cs_n = 1'b1;
    // released line must not keep the last bit
    si = ~si;
    -> done;
    // select held high through the gap
    #(gap * 8);
  endtask : frame
endmodule : spi_host

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  typedef struct {
    logic [63:0] v;
    int n;
  } exp_s;
  // identity values are arbitrary
  localparam logic [7:0] MFR = 8'hC3;
  localparam logic [7:0] DEV = 8'h2B;
  localparam logic [7:0] TYP = 8'h61;
  localparam logic [7:0] CAP = 8'h15;
  localparam logic [127:0] HDR = 128'hFF00003009010000FF00010050444653;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic busy = 1'b0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] rdata, req_op;
  logic [23:0] req_addr;
  logic [31:0] lfsr = 32'h17E4;
  wire logic cs_n, sck, si, so, so_oe, req, req_otp, otp_map, sleep;
  int bad_count = 0;
  int compares = 0;
  exp_s fq[$];
  logic [7:0] rq[$];
  logic [32:0] aq[$];

  always #4 ref_clk = ~ref_clk;

  flash_cmd_top #(.MFR_CODE(MFR), .DEV_CODE(DEV), .MEM_TYPE(TYP),
    .MEM_CAPACITY(CAP)) i_dut (.REF_CLK(ref_clk), .NRST(nrst), .CS_N(cs_n),
    .SCK(sck), .SI(si), .SO(so), .SO_OE(so_oe), .ARRAY_BUSY(busy),
    .ARRAY_REQ(req), .ARRAY_REQ_OP(req_op), .ARRAY_REQ_ADDR(req_addr),
    .ARRAY_REQ_OTP(req_otp), .OTP_MAP(otp_map), .DEEP_SLEEP(sleep),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(wr_stb),
    .REG_RD(rd_stb), .REG_RDATA(rdata));
  spi_host i_host (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));

  function automatic logic [31:0] step(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : step

  function automatic logic [63:0] tbl(input logic [7:0] a);
    logic [63:0] r;
    logic [7:0] b;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      b = a + 8'(i);
      r = {r[55:0], b < 8'h10 ? HDR[8 * b[3:0] +: 8] : 8'hFF};
    end
    return r;
  endfunction : tbl

  task automatic cmp_data(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_data

  task automatic cmp_req(input logic [32:0] got, input logic [32:0] exp);
    cmp_data(64'(got), 64'(exp));
  endtask : cmp_req

  task automatic results;
    if (fq.size() + rq.size() + aq.size() != 0) bad_count++;
    if (bad_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, input logic [7:0] d);
    rq.push_back(d);
    @(posedge ref_clk);
    reg_addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
  endtask : reg_read

  task automatic spi(input logic [7:0] tx[$], input int nclk, input int nexp,
                     input logic [63:0] v);
    fq.push_back('{v, nexp});
    // start off the clock edge so no pin edge races the sampler
    @(posedge ref_clk);
    #0.25;
    i_host.frame(tx, nclk, 10);
  endtask : spi

  task automatic erase(input logic [7:0] op, input logic [23:0] a,
                       input logic ok, input logic otp);
    if (ok) aq.push_back({otp, op, a});
    spi('{op, a[23:16], a[15:8], a[7:0]}, 0, 0, '0);
  endtask : erase

  task automatic wake_check(input int lo, input int hi);
    repeat (lo) @(posedge ref_clk);
    cmp_data(64'(sleep), 64'h1);
    repeat (hi - lo) @(posedge ref_clk);
    cmp_data(64'(sleep), 64'h0);
  endtask : wake_check

  always @(i_host.done) begin
    exp_s e;
    e = fq.pop_front();
    if (e.n == 0)
      cmp_data(64'(i_host.oe_seen), 64'h0);
    else
      cmp_data(i_host.rx & ((64'h1 << (8 * e.n)) - 64'h1), e.v);
  end

  always @(posedge ref_clk) begin
    if (rd_q) cmp_data(64'(rdata), 64'(rq.pop_front()));
    if (req === 1'b1)
      cmp_req({req_otp, req_op, req_addr},
              aq.size() != 0 ? aq.pop_front() : 33'h1FFFFFFFF);
    rd_q <= rd_stb;
  end

  initial begin
    #400000;
    bad_count++;
    results();
  end

  initial begin
    logic [7:0] st;
    logic [23:0] ad;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reg_write(8'h00, 8'h8A);
    reg_read(8'h00, 8'h8A);
    reg_read(8'h7E, 8'h00);
    reg_write(8'h01, 8'hFF);
    reg_read(8'h01, 8'h00);
    reg_write(8'h00, 8'h00);
    spi('{8'h9F}, 4, 4, {MFR, TYP, CAP, MFR});
    for (int a = 0; a < 2; a++) begin
      spi('{8'h90, 8'h00, 8'h00, 8'(a)}, 4, 4,
          a ? {DEV, MFR, DEV, MFR} : {MFR, DEV, MFR, DEV});
    end
    spi('{8'hAB, 8'h00, 8'h00, 8'h00}, 2, 2, {DEV, DEV});
    for (int i = 0; i < 5; i++) begin
      lfsr = step(lfsr);
      st = i < 2 ? 8'(8 * i) : (i == 2 ? 8'hFE : lfsr[7:0]);
      spi('{8'h5A, lfsr[31:24], lfsr[23:16], st, lfsr[15:8]}, 8, 8,
          tbl(st));
    end
    @(posedge ref_clk);
    busy <= 1'b1;
    spi('{8'h9F}, 2, 0, '0);
    spi('{8'hAB, 8'h00, 8'h00, 8'h00}, 1, 0, '0);
    spi('{8'h5A, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 0, '0);
    @(posedge ref_clk);
    busy <= 1'b0;
    lfsr = step(lfsr);
    erase(8'h20, {8'h00, lfsr[15:0]}, 1'b1, 1'b0);
    spi('{8'hB9}, 0, 0, '0);
    cmp_data(64'(sleep), 64'h1);
    spi('{8'h90, 8'h00, 8'h00, 8'h00}, 2, 0, '0);
    erase(8'h20, 24'h000100, 1'b0, 1'b0);
    spi('{8'hAB, 8'h00, 8'h00, 8'h00}, 2, 2, {DEV, DEV});
    wake_check(200, 250);
    spi('{8'hB9}, 0, 0, '0);
    spi('{8'hAB}, 0, 0, '0);
    wake_check(350, 400);
    spi('{8'h9F}, 1, 1, 64'(MFR));
    spi('{8'h3A}, 0, 0, '0);
    cmp_data(64'(otp_map), 64'h1);
    reg_write(8'h00, 8'h81);
    spi('{8'h05}, 1, 1, 64'h04);
    lfsr = step(lfsr);
    ad = {15'h0FF8, lfsr[8:0]};
    erase(8'h20, ad, 1'b0, 1'b1);
    reg_write(8'h00, 8'h00);
    erase(8'h20, ad, 1'b1, 1'b1);
    erase(8'hD8, ad, 1'b0, 1'b1);
    spi('{8'hC7}, 0, 0, '0);
    aq.push_back({1'b1, 8'h02, ad});
    spi('{8'h02, ad[23:16], ad[15:8], ad[7:0], lfsr[7:0]}, 0, 0, '0);
    spi('{8'h01, 8'h00}, 0, 0, '0);
    spi('{8'h05}, 2, 2, 64'h8080);
    erase(8'h20, ad, 1'b0, 1'b1);
    spi('{8'h04}, 0, 0, '0);
    cmp_data(64'(otp_map), 64'h0);
    results();
  end
endmodule : testbench

`default_nettype wire
